// file: hw/dcrb_pkg.sv
package dcrb_pkg;

	// Register offsets (byte addresses on the configuration interface)
	localparam logic [7:0] DCRB_OFS_PIN_SETUP_SECOND = 8'hA6;
	localparam logic [7:0] DCRB_OFS_DEVICE_SETUP     = 8'hA8;
	localparam logic [7:0] DCRB_OFS_GATE_ONE         = 8'hAC;
	localparam logic [7:0] DCRB_OFS_GATE_TWO         = 8'hAE;

	// Reset values
	localparam logic [31:0] DCRB_RST_DEVICE_SETUP = 32'h0000_0000;
	localparam logic [31:0] DCRB_RST_PIN_SECOND   = 32'h0000_0000;
	localparam logic [31:0] DCRB_RST_GATE_ONE     = 32'h0022_8000;
	localparam logic [31:0] DCRB_RST_GATE_TWO     = 32'h0000_0000;

	// Writable bit masks; reserved bits stay zero
	localparam logic [31:0] DCRB_MASK_DEVICE_SETUP = 32'hFFFF_CF78;
	localparam logic [31:0] DCRB_MASK_PIN_SECOND   = 32'hE80F_E000;
	localparam logic [31:0] DCRB_MASK_GATE         = 32'hFFFF_FFFF;

	// Device setup field positions
	localparam int DCRB_POS_MAX_FREQ_HI  = 30;
	localparam int DCRB_POS_MAX_FREQ_LO  = 16;
	localparam int DCRB_POS_SAFETY_LIB   = 15;
	localparam int DCRB_POS_SPREAD_OFF   = 14;
	localparam int DCRB_POS_LOW_POWER    = 11;
	localparam int DCRB_POS_PWM_BAND     = 10;
	localparam int DCRB_POS_CLK_SRC_HI   = 9;
	localparam int DCRB_POS_CLK_SRC_LO   = 8;
	localparam int DCRB_POS_OCLK_EN      = 6;
	localparam int DCRB_POS_OCLK_RATE_HI = 5;
	localparam int DCRB_POS_OCLK_RATE_LO = 3;

	// Pin setup second field positions
	localparam int DCRB_POS_WD_ENABLE    = 17;
	localparam int DCRB_POS_WD_SOURCE    = 16;
	localparam int DCRB_POS_WD_RATE_HI   = 14;
	localparam int DCRB_POS_WD_RATE_LO   = 13;

	// Speed source select position in the first pin setup word
	localparam int DCRB_POS_SPD_SRC_HI   = 2;
	localparam int DCRB_POS_SPD_SRC_LO   = 1;

	// Encodings
	localparam logic [1:0] DCRB_CLK_INTERNAL = 2'h0;
	localparam logic [1:0] DCRB_CLK_OUTSIDE  = 2'h3;
	localparam logic [1:0] DCRB_SPD_FREQ     = 2'h3;

	// Watchdog service periods in ms per rate code 0..3 (10,5,2,1 Hz)
	localparam int DCRB_WD_PERIOD_MS0 = 100;
	localparam int DCRB_WD_PERIOD_MS1 = 200;
	localparam int DCRB_WD_PERIOD_MS2 = 500;
	localparam int DCRB_WD_PERIOD_MS3 = 1000;

	// Outside clock base rate in kHz; code n gives base << n
	localparam logic [10:0] DCRB_OCLK_BASE_KHZ = 11'h008;

endpackage : dcrb_pkg

// file: hw/dcrb_device_config_bank.sv
// Operation
// - Watchdog rate code selects 10,5,2,1 Hz
// - Device setup at A8h, resets zero
// - Bits 30:16 hold frequency input ceiling
// - Bit 15 enables safety library
// - Bit 14 set turns spread spectrum off
// - Bit 11 picks standby or sleep
// - Bit 10 picks speed PWM band
// - Clock source: 0 internal, 3 outside
// - Bit 6 enables outside clock input
// - Outside clock rate is 8 kHz shl code
// - Gate driver words at ACh and AEh
// - Speed code 3 applies frequency ceiling
// - Watchdog needs enable; source bus or pin
`timescale 1ns/1ps
`default_nettype none

module dcrb_device_config_bank
	import dcrb_pkg::*;
(
	input  wire logic        i_core_clk,
	input  wire logic        i_reset,
	input  wire logic        i_wr_en,
	input  wire logic        i_rd_en,
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wr_data,
	input  wire logic [1:0]  i_speed_source_select,
	output logic      [31:0] o_rd_data,
	output logic             o_rd_valid,
	output logic             o_addr_error,
	output logic      [14:0] o_freq_ceiling_hz,
	output logic             o_freq_ceiling_active,
	output logic             o_safety_library_enable,
	output logic             o_spread_spectrum_active,
	output logic             o_low_power_sleep,
	output logic             o_speed_pwm_band_low,
	output logic             o_use_outside_clock,
	output logic             o_clock_select_invalid,
	output logic             o_outside_clock_enable,
	output logic      [10:0] o_outside_clock_khz,
	output logic             o_watchdog_active,
	output logic             o_watchdog_from_pin,
	output logic      [9:0]  o_watchdog_period_ms,
	output logic      [31:0] o_gate_drive_setup_one,
	output logic      [31:0] o_gate_drive_setup_two
);

	logic [31:0] device_setup_reg;
	logic [31:0] pin_second_reg;
	logic [31:0] gate_one_reg;
	logic [31:0] gate_two_reg;
	logic [31:0] rd_data_next;
	logic        hit_next;
	logic        wr_device_setup;
	logic        wr_pin_second;
	logic        wr_gate_one;
	logic        wr_gate_two;
	logic [14:0] ceiling_field;
	logic [2:0]  oclk_code;
	logic [1:0]  wd_rate_code;

	// Only the four mapped offsets decode; anything else is flagged
	function automatic logic dcrb_is_mapped(input logic [7:0] a);
		return (a == DCRB_OFS_DEVICE_SETUP) || (a == DCRB_OFS_PIN_SETUP_SECOND)
			|| (a == DCRB_OFS_GATE_ONE) || (a == DCRB_OFS_GATE_TWO);
	endfunction : dcrb_is_mapped

	// One strobe per register keeps the write blocks free of decode
	function automatic logic dcrb_wr_hit(input logic en, input logic [7:0] a,
		input logic [7:0] ofs);
		return en && (a == ofs);
	endfunction : dcrb_wr_hit

	function automatic logic [1:0] dcrb_clk_code(input logic [31:0] w);
		return w[DCRB_POS_CLK_SRC_HI:DCRB_POS_CLK_SRC_LO];
	endfunction : dcrb_clk_code

	function automatic logic [9:0] dcrb_wd_period(input logic [1:0] c);
		logic [9:0] p;
		p = 10'(DCRB_WD_PERIOD_MS0);
		unique case (c)
			2'h0: p = 10'(DCRB_WD_PERIOD_MS0);
			2'h1: p = 10'(DCRB_WD_PERIOD_MS1);
			2'h2: p = 10'(DCRB_WD_PERIOD_MS2);
			2'h3: p = 10'(DCRB_WD_PERIOD_MS3);
		endcase
		return p;
	endfunction : dcrb_wd_period

	// Eight shifted by at most seven is 1024, which still fits 11 bits
	function automatic logic [10:0] dcrb_oclk_khz(input logic [2:0] c);
		return DCRB_OCLK_BASE_KHZ << c;
	endfunction : dcrb_oclk_khz

	always_comb begin
		wr_device_setup = dcrb_wr_hit(i_wr_en, i_addr,
			DCRB_OFS_DEVICE_SETUP);
		wr_pin_second   = dcrb_wr_hit(i_wr_en, i_addr,
			DCRB_OFS_PIN_SETUP_SECOND);
		wr_gate_one     = dcrb_wr_hit(i_wr_en, i_addr,
			DCRB_OFS_GATE_ONE);
		wr_gate_two     = dcrb_wr_hit(i_wr_en, i_addr,
			DCRB_OFS_GATE_TWO);
	end

	// Named views of stored fields, read by the output flops below
	always_comb begin
		ceiling_field = device_setup_reg[DCRB_POS_MAX_FREQ_HI:
			DCRB_POS_MAX_FREQ_LO];
		oclk_code     = device_setup_reg[DCRB_POS_OCLK_RATE_HI:
			DCRB_POS_OCLK_RATE_LO];
		wd_rate_code  = pin_second_reg[DCRB_POS_WD_RATE_HI:
			DCRB_POS_WD_RATE_LO];
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			device_setup_reg <= DCRB_RST_DEVICE_SETUP;
		end else if (wr_device_setup) begin
			// Masking keeps reserved bits at zero whatever is written
			device_setup_reg <= i_wr_data & DCRB_MASK_DEVICE_SETUP;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			pin_second_reg <= DCRB_RST_PIN_SECOND;
		end else if (wr_pin_second) begin
			pin_second_reg <= i_wr_data & DCRB_MASK_PIN_SECOND;
		end
	end

	// Gate words are stored whole; their fields belong to the gate driver
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			gate_one_reg <= DCRB_RST_GATE_ONE;
		end else if (wr_gate_one) begin
			gate_one_reg <= i_wr_data & DCRB_MASK_GATE;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			gate_two_reg <= DCRB_RST_GATE_TWO;
		end else if (wr_gate_two) begin
			gate_two_reg <= i_wr_data & DCRB_MASK_GATE;
		end
	end

	always_comb begin
		hit_next     = dcrb_is_mapped(i_addr);
		rd_data_next = 32'h0000_0000;
		unique case (i_addr)
			DCRB_OFS_DEVICE_SETUP:     rd_data_next = device_setup_reg;
			DCRB_OFS_PIN_SETUP_SECOND: rd_data_next = pin_second_reg;
			DCRB_OFS_GATE_ONE:         rd_data_next = gate_one_reg;
			DCRB_OFS_GATE_TWO:         rd_data_next = gate_two_reg;
			// Reserved offsets read zero and ignore writes
			default:                   rd_data_next = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			o_rd_valid <= 1'b0;
		end else begin
			o_rd_valid <= i_rd_en;
		end
	end

	// Pulses for writes as well, so a stray write is not silent
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			o_addr_error <= 1'b0;
		end else begin
			o_addr_error <= (i_rd_en || i_wr_en) && !hit_next;
		end
	end

	// Read data holds between reads so a slow reader may take it later
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			o_rd_data <= 32'h0000_0000;
		end else if (i_rd_en) begin
			o_rd_data <= rd_data_next;
		end
	end

	// Decoded controls, registered so outputs come from flip-flops
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			o_freq_ceiling_hz <= 15'h0000;
		end else begin
			o_freq_ceiling_hz <= ceiling_field;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			o_freq_ceiling_active <= 1'b0;
		end else begin
			o_freq_ceiling_active <=
				(i_speed_source_select == DCRB_SPD_FREQ);
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			o_safety_library_enable <= 1'b0;
		end else begin
			o_safety_library_enable <=
				device_setup_reg[DCRB_POS_SAFETY_LIB];
		end
	end

	// Inverted sense: zero leaves modulation running
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			o_spread_spectrum_active <= 1'b1;
		end else begin
			o_spread_spectrum_active <=
				!device_setup_reg[DCRB_POS_SPREAD_OFF];
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			o_low_power_sleep <= 1'b0;
		end else begin
			o_low_power_sleep <= device_setup_reg[DCRB_POS_LOW_POWER];
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			o_speed_pwm_band_low <= 1'b0;
		end else begin
			o_speed_pwm_band_low <= device_setup_reg[DCRB_POS_PWM_BAND];
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			o_use_outside_clock <= 1'b0;
		end else begin
			o_use_outside_clock <=
				(dcrb_clk_code(device_setup_reg) == DCRB_CLK_OUTSIDE);
		end
	end

	// Undefined codes fall back to the internal oscillator
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			o_clock_select_invalid <= 1'b0;
		end else begin
			o_clock_select_invalid <=
				(dcrb_clk_code(device_setup_reg) != DCRB_CLK_OUTSIDE)
				&& (dcrb_clk_code(device_setup_reg) != DCRB_CLK_INTERNAL);
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			o_outside_clock_enable <= 1'b0;
		end else begin
			o_outside_clock_enable <= device_setup_reg[DCRB_POS_OCLK_EN];
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			o_outside_clock_khz <= dcrb_oclk_khz(3'h0);
		end else begin
			o_outside_clock_khz <= dcrb_oclk_khz(oclk_code);
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			o_watchdog_active <= 1'b0;
		end else begin
			o_watchdog_active <= pin_second_reg[DCRB_POS_WD_ENABLE];
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			o_watchdog_from_pin <= 1'b0;
		end else begin
			o_watchdog_from_pin <= pin_second_reg[DCRB_POS_WD_SOURCE];
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			o_watchdog_period_ms <= dcrb_wd_period(2'h0);
		end else begin
			o_watchdog_period_ms <= dcrb_wd_period(wd_rate_code);
		end
	end

	assign o_gate_drive_setup_one = gate_one_reg;
	assign o_gate_drive_setup_two = gate_two_reg;

endmodule : dcrb_device_config_bank

`default_nettype wire

// file: verif/dcrb_device_config_bank_chk.sv
`timescale 1ns/1ps
`default_nettype none
module dcrb_device_config_bank_chk
	import dcrb_pkg::*;
(
	input wire logic        i_core_clk,
	input wire logic        i_reset,
	input wire logic        i_wr_en,
	input wire logic        i_rd_en,
	input wire logic [7:0]  i_addr,
	input wire logic [31:0] i_wr_data,
	input wire logic [31:0] o_rd_data,
	input wire logic        o_rd_valid,
	input wire logic        o_addr_error,
	input wire logic [14:0] o_freq_ceiling_hz,
	input wire logic        o_safety_library_enable,
	input wire logic        o_spread_spectrum_active,
	input wire logic        o_low_power_sleep,
	input wire logic        o_speed_pwm_band_low,
	input wire logic        o_use_outside_clock,
	input wire logic        o_clock_select_invalid,
	input wire logic        o_outside_clock_enable,
	input wire logic [10:0] o_outside_clock_khz
);
	logic [31:0] d1;
	logic [31:0] d2;
	logic [31:0] d3;
	logic        bad;
	// Write data delayed to line up with the decoded outputs
	always_ff @(posedge i_core_clk) begin
		d1 <= i_wr_data;
		d2 <= d1;
		d3 <= d2;
	end
	assign bad = !(i_addr inside {DCRB_OFS_PIN_SETUP_SECOND,
		DCRB_OFS_DEVICE_SETUP, DCRB_OFS_GATE_ONE, DCRB_OFS_GATE_TWO});
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_reset);
	sequence dev_wr;
		i_wr_en && i_addr == DCRB_OFS_DEVICE_SETUP;
	endsequence
	sequence dev_set;
		dev_wr ##1 !(i_wr_en && i_addr == DCRB_OFS_DEVICE_SETUP) ##1 1'b1;
	endsequence
	unmap_err_a: assert property ((i_wr_en || i_rd_en) && bad |=> o_addr_error)
		else $error("unmapped access gave no error pulse");
	unmap_zero_a: assert property (i_rd_en && bad |=> o_rd_data == 32'h0)
		else $error("unmapped read not zero");
	rd_mask_a: assert property (dev_set ##0 (i_rd_en &&
		!i_wr_en && i_addr == DCRB_OFS_DEVICE_SETUP) |=>
		o_rd_data == (d3 & 32'hFFFF_CF78))
		else $error("device setup readback wrong");
	ceil_field_a: assert property (dev_set |-> o_freq_ceiling_hz == d2[30:16])
		else $error("ceiling field wrong");
	spread_inv_a: assert property (dev_set |-> o_spread_spectrum_active != d2[14])
		else $error("spread spectrum sense wrong");
	mode_bits_a: assert property (dev_set |-> {o_safety_library_enable,
		o_low_power_sleep, o_speed_pwm_band_low, o_outside_clock_enable} ==
		{d2[15], d2[11], d2[10], d2[6]}) else $error("mode bits wrong");
	clk_sel_a: assert property (dev_set |-> o_use_outside_clock == (d2[9:8] == 2'h3)
		&& o_clock_select_invalid == (d2[9:8] == 2'h1 || d2[9:8] == 2'h2))
		else $error("clock source decode wrong");
	oclk_rate_a: assert property (dev_set |-> o_outside_clock_khz == (11'h008 << d2[5:3]))
		else $error("outside clock rate wrong");
endmodule : dcrb_device_config_bank_chk
bind dcrb_device_config_bank dcrb_device_config_bank_chk u_chk (.i_core_clk,
	.i_reset, .i_wr_en, .i_rd_en, .i_addr, .i_wr_data, .o_rd_data, .o_rd_valid,
	.o_addr_error, .o_freq_ceiling_hz, .o_safety_library_enable,
	.o_spread_spectrum_active, .o_low_power_sleep, .o_speed_pwm_band_low,
	.o_use_outside_clock, .o_clock_select_invalid, .o_outside_clock_enable,
	.o_outside_clock_khz);
`default_nettype wire

// file: verif/dcrb_device_config_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dcrb_device_config_bank_tb import dcrb_pkg::*;;
	logic        i_core_clk = 1'b0, i_reset = 1'b1, i_wr_en = 1'b0, i_rd_en = 1'b0;
	logic [7:0]  i_addr = 8'h00;
	logic [31:0] i_wr_data = 32'h0000_0000;
	logic [1:0]  i_speed_source_select = 2'h0;
	logic [31:0] o_rd_data, o_gate_drive_setup_one, o_gate_drive_setup_two;
	logic [14:0] o_freq_ceiling_hz;
	logic [10:0] o_outside_clock_khz;
	logic [9:0]  o_watchdog_period_ms;
	logic        o_rd_valid, o_addr_error, o_freq_ceiling_active, o_watchdog_active,
		o_safety_library_enable, o_spread_spectrum_active, o_low_power_sleep,
		o_speed_pwm_band_low, o_use_outside_clock, o_clock_select_invalid,
		o_outside_clock_enable, o_watchdog_from_pin;
	int          num_errors = 0, total_checks = 0;
	always #2 i_core_clk = ~i_core_clk;
	dcrb_device_config_bank u_dut (.i_core_clk, .i_reset, .i_wr_en, .i_rd_en,
		.i_addr, .i_wr_data, .i_speed_source_select, .o_rd_data, .o_rd_valid,
		.o_addr_error, .o_freq_ceiling_hz, .o_freq_ceiling_active,
		.o_safety_library_enable, .o_spread_spectrum_active, .o_low_power_sleep,
		.o_speed_pwm_band_low, .o_use_outside_clock, .o_clock_select_invalid,
		.o_outside_clock_enable, .o_outside_clock_khz, .o_watchdog_active,
		.o_watchdog_from_pin, .o_watchdog_period_ms, .o_gate_drive_setup_one,
		.o_gate_drive_setup_two);
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic tick;
		@(posedge i_core_clk);
		#1;
	endtask : tick
	// Idle cycle after each strobe so no signal is driven twice in one step
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		i_wr_en = 1'b1;
		i_addr = a;
		i_wr_data = d;
		tick();
		i_wr_en = 1'b0;
		tick();
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic er);
		i_rd_en = 1'b1;
		i_addr = a;
		tick();
		chk("rd_valid", o_rd_valid, 32'h1);
		chk("rd_data", o_rd_data, e);
		chk("addr_error", o_addr_error, er);
		i_rd_en = 1'b0;
		tick();
		chk("rd_valid_low", o_rd_valid, 32'h0);
		chk("rd_hold", o_rd_data, e);
	endtask : rd
	task automatic t_reset;
		rd(DCRB_OFS_DEVICE_SETUP, 32'h0000_0000, 1'b0);
		rd(DCRB_OFS_GATE_ONE, DCRB_RST_GATE_ONE, 1'b0);
		rd(DCRB_OFS_GATE_TWO, DCRB_RST_GATE_TWO, 1'b0);
		chk("spread", o_spread_spectrum_active, 32'h1);
		chk("khz", o_outside_clock_khz, 32'h8);
		chk("wd_ms", o_watchdog_period_ms, 32'h64);
		$display("t_reset done");
	endtask : t_reset
	task automatic t_dev;
		wr(DCRB_OFS_DEVICE_SETUP, 32'hFFFF_FFFF);
		rd(DCRB_OFS_DEVICE_SETUP, 32'hFFFF_CF78, 1'b0);
		chk("ceil", o_freq_ceiling_hz, 32'h7FFF);
		chk("flags", {o_safety_library_enable, o_spread_spectrum_active,
			o_low_power_sleep, o_speed_pwm_band_low, o_outside_clock_enable}, 32'h17);
		for (int k = 0; k < 32; k++) begin
			wr(DCRB_OFS_DEVICE_SETUP, {22'h0, k[4:3], 2'h0, k[2:0], 3'h0});
			chk("clk_src", {o_use_outside_clock, o_clock_select_invalid},
				{k[4:3] == 2'h3, k[4:3] == 2'h1 || k[4:3] == 2'h2});
			chk("khz", o_outside_clock_khz, 32'h8 << k[2:0]);
		end
		$display("t_dev done");
	endtask : t_dev
	task automatic t_wd;
		logic [31:0] per [4] = '{32'h64, 32'hC8, 32'h1F4, 32'h3E8};
		for (int k = 0; k < 16; k++) begin
			wr(DCRB_OFS_PIN_SETUP_SECOND, {14'h0, k[3:2], 1'h0, k[1:0], 13'h0});
			chk("wd_on", {o_watchdog_active, o_watchdog_from_pin}, k[3:2]);
			chk("wd_ms", o_watchdog_period_ms, per[k[1:0]]);
		end
		$display("t_wd done");
	endtask : t_wd
	task automatic t_gate;
		wr(DCRB_OFS_GATE_ONE, 32'hA5C3_0F96);
		wr(DCRB_OFS_GATE_TWO, 32'h5A3C_F069);
		wr(8'hA0, 32'hFFFF_FFFF); // Stray write kept outside the gate group
		rd(DCRB_OFS_GATE_ONE, 32'hA5C3_0F96, 1'b0);
		rd(DCRB_OFS_GATE_TWO, 32'h5A3C_F069, 1'b0);
		chk("gate_two", o_gate_drive_setup_two, 32'h5A3C_F069);
		chk("gate_one", o_gate_drive_setup_one, 32'hA5C3_0F96);
		rd(8'hA0, 32'h0000_0000, 1'b1);
		rd(DCRB_OFS_DEVICE_SETUP, 32'h0000_0338, 1'b0);
		$display("t_gate done");
	endtask : t_gate
	task automatic t_speed;
		for (int k = 0; k < 4; k++) begin
			i_speed_source_select = k[1:0];
			tick();
			tick();
			chk("ceil_active", o_freq_ceiling_active, k == 3);
		end
		$display("t_speed done");
	endtask : t_speed
	// Second reset in mid-run, after every register has been dirtied
	task automatic t_rerst;
		wr(DCRB_OFS_PIN_SETUP_SECOND, 32'hFFFF_FFFF);
		rd(DCRB_OFS_PIN_SETUP_SECOND, 32'hE80F_E000, 1'b0);
		wr(DCRB_OFS_DEVICE_SETUP, 32'h7FFF_C000);
		i_reset = 1'b1;
		tick();
		tick();
		i_reset = 1'b0;
		rd(DCRB_OFS_DEVICE_SETUP, 32'h0000_0000, 1'b0);
		rd(DCRB_OFS_PIN_SETUP_SECOND, 32'h0000_0000, 1'b0);
		rd(DCRB_OFS_GATE_ONE, DCRB_RST_GATE_ONE, 1'b0);
		chk("gate_one_rst", o_gate_drive_setup_one, DCRB_RST_GATE_ONE);
		chk("flags_rst", {o_safety_library_enable,
			o_spread_spectrum_active}, 32'h1);
		chk("ceil_rst", o_freq_ceiling_hz, 32'h0);
		chk("wd_rst", {o_watchdog_active, o_watchdog_period_ms},
			32'h64);
		$display("t_rerst done");
	endtask : t_rerst
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : give_verdict
	initial begin
		repeat (16) @(posedge i_core_clk);
		#1;
		i_reset = 1'b0;
		t_reset();
		t_dev();
		t_wd();
		t_gate();
		t_speed();
		t_rerst();
		give_verdict();
	end
	// Tests need well under 300 cycles; a hang is cut off far beyond that
	initial begin
		#20000;
		num_errors++;
		give_verdict();
	end
endmodule : dcrb_device_config_bank_tb
`default_nettype wire
